/* rtl/sbecc_pkg.sv */
// package of the sector buffer / ecc glue: constants, modes, phases
// assumes a single 100 MHz system clock shared by both ends
package sbecc_pkg;
    localparam int CLK_MHZ = 100;
    // reset timing, figures in their own units
    localparam int WARM_MIN_NS = 15000;
    localparam int WARM_MIN_CYC = (WARM_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int WARM_PULSE_US = 1350;
    localparam int WARM_PULSE_CYC = WARM_PULSE_US * CLK_MHZ;
    localparam int COLD_MIN_MS = 10;
    localparam int COLD_MIN_CYC = COLD_MIN_MS * 1000 * CLK_MHZ;
    localparam int COLD_PULSE_MS = 128;
    localparam int COLD_PULSE_CYC = COLD_PULSE_MS * 1000 * CLK_MHZ;
    localparam int RST_CW = 24;
    // sector buffer addressing
    localparam int CNT_W = 10;
    localparam int PAGE_LSB = 7;
    localparam logic [2:0] CMD_LAST = 3'h5;
    localparam logic [1:0] TAIL_LAST = 2'h3;
    // check codes
    localparam logic [31:0] ECC_POLY = 32'h04C11DB7;
    localparam logic [31:0] ECC_INIT = 32'h00000000;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    // correction span
    localparam logic [3:0] SPAN_RST = 4'h5;
    localparam logic [3:0] SPAN_MAX = 4'hB;
    localparam logic [3:0] RETRY_MAX = 4'h8;
    // apb register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0C;
    localparam logic [7:0] REG_SYN = 8'h10;
    // ctrl fields
    localparam int C_ECC = 0;
    localparam int C_DMA = 1;
    localparam int C_IDCHK = 2;
    localparam int C_MODE = 4;
    localparam int C_PAGE = 8;
    localparam int C_SPAN = 12;
    // cmd strobe bits, byte to write in bits 15:8
    localparam int K_PAGE = 0;
    localparam int K_ACC = 1;
    localparam int K_WR = 2;
    localparam int K_XFER = 3;
    localparam int K_CMD = 4;
    localparam int K_BYTE = 8;
    // status fields
    localparam int S_ADDR = 0;
    localparam int S_NZ = 11;
    localparam int S_CRDY = 12;
    localparam int S_IDERR = 13;
    localparam int S_TF = 14;
    localparam int S_TFV = 17;
    localparam int S_OPT = 18;
    localparam int S_WARM = 22;
    localparam int S_COLD = 23;
    localparam int S_ABORT = 24;
    localparam int S_MATCH = 25;
    localparam int S_RETRY = 26;
    localparam int S_EXH = 30;
    localparam int S_WEOK = 31;
    typedef enum logic [1:0] {
        SBECC_WR = 2'b00,
        SBECC_RD = 2'b01,
        SBECC_WLONG = 2'b10,
        SBECC_RLONG = 2'b11
    } sbecc_mode_e;
    typedef enum logic [1:0] {
        SBECC_DATA = 2'b00,
        SBECC_TAIL = 2'b01,
        SBECC_DONE = 2'b10
    } sbecc_phase_e;
endpackage

/* rtl/sbecc_if.sv */
// local bus between the buffer manager processor end and the logic array
// assumes both ends run on the same clock; the bus wire is resolved here
`timescale 1ns/1ns
interface sbecc_if;
    import sbecc_pkg::*;
    // processor to logic array
    logic page_ld;
    logic [2:0] page_sel;
    logic ram_acc;
    logic ram_wr;
    logic xfer_start;
    sbecc_mode_e xfer_mode;
    logic ecc_sel;
    logic dma_en;
    logic id_chk;
    logic cmd_start;
    logic [7:0] ad_p_o;
    logic ad_p_oe;
    // logic array to processor
    logic [10:0] ra;
    logic [2:0] tf_addr;
    logic tf_valid;
    logic ecc_nz;
    logic [31:0] ecc_syn;
    logic id_err;
    logic ram_we_ok;
    logic [3:0] opt;
    logic rst_warm;
    logic rst_cold;
    logic [7:0] ad_d_o;
    logic ad_d_oe;
    // shared byte bus, reads zero when nobody drives
    logic [7:0] ad;
    assign ad = ad_p_oe ? ad_p_o : (ad_d_oe ? ad_d_o : 8'h00);
    modport dev (
        input page_ld, page_sel, ram_acc, ram_wr, xfer_start, xfer_mode,
        input ecc_sel, dma_en, id_chk, cmd_start, ad,
        output ra, tf_addr, tf_valid, ecc_nz, ecc_syn, id_err, ram_we_ok,
        output opt, rst_warm, rst_cold, ad_d_o, ad_d_oe
    );
    modport proc (
        output page_ld, page_sel, ram_acc, ram_wr, xfer_start, xfer_mode,
        output ecc_sel, dma_en, id_chk, cmd_start, ad_p_o, ad_p_oe,
        input ra, tf_addr, tf_valid, ecc_nz, ecc_syn, id_err, ram_we_ok,
        input opt, rst_warm, rst_cold, ad
    );
endinterface

/* rtl/sbecc_proc.sv */
// buffer manager end: apb slave registers that drive the local bus
// assumes apb on CLK_SYS; drive status pins arrive asynchronously
`timescale 1ns/1ns
module sbecc_proc
    import sbecc_pkg::*;
(
    // clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic CE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    // drive status pins
    input wire logic DRIVE_READY_IN,
    input wire logic SEEK_DONE_IN,
    input wire logic WRITE_FAULT_IN,
    // local bus
    sbecc_if.proc LB
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic ecc_sel, dma_en, id_chk;
        sbecc_mode_e mode;
        logic [2:0] page;
        logic [3:0] span;
        logic page_ld, ram_acc, ram_wr, xfer, cmd;
        logic [7:0] ad_o;
        logic ad_oe;
        logic [7:0] rbyte;
        logic abort;
        logic [31:0] prev_syn;
        logic match;
        logic [3:0] retry;
        logic pready, pslverr;
        logic [31:0] prdata;
    } sbecc_proc_s;
    sbecc_proc_s q, n;
    logic drive_ok;
    logic [31:0] stat;

    always_comb begin
        n = q;
        n.s1 = {DRIVE_READY_IN, SEEK_DONE_IN, WRITE_FAULT_IN};
        n.s2 = q.s1;
        drive_ok = q.s2[2] & q.s2[1] & ~q.s2[0];
        stat = 32'h00000000;
        stat[S_ADDR +: 11] = LB.ra;
        stat[S_NZ] = LB.ecc_nz;
        stat[S_CRDY] = LB.ra[3];
        stat[S_IDERR] = LB.id_err;
        stat[S_TF +: 3] = LB.tf_addr;
        stat[S_TFV] = LB.tf_valid;
        stat[S_OPT +: 4] = LB.opt;
        stat[S_WARM] = LB.rst_warm;
        stat[S_COLD] = LB.rst_cold;
        stat[S_ABORT] = q.abort;
        stat[S_MATCH] = q.match;
        stat[S_RETRY +: 4] = q.retry;
        stat[S_EXH] = (q.retry >= RETRY_MAX);
        stat[S_WEOK] = LB.ram_we_ok;
        n.page_ld = 1'b0;
        n.ram_acc = 1'b0;
        n.ram_wr = 1'b0;
        n.xfer = 1'b0;
        n.cmd = 1'b0;
        n.ad_oe = 1'b0;
        if (q.ram_acc && !q.ram_wr) begin
            n.rbyte = LB.ad;
        end
        if (PSEL && PENABLE && !q.pready) begin
            // one wait state, answer registered
            n.pready = 1'b1;
            n.pslverr = 1'b0;
            n.prdata = 32'h00000000;
            case (PADDR)
                REG_CTRL: begin
                    n.prdata[C_ECC] = q.ecc_sel;
                    n.prdata[C_DMA] = q.dma_en;
                    n.prdata[C_IDCHK] = q.id_chk;
                    n.prdata[C_MODE +: 2] = q.mode;
                    n.prdata[C_PAGE +: 3] = q.page;
                    n.prdata[C_SPAN +: 4] = q.span;
                end
                REG_CMD: n.prdata = 32'h00000000;
                REG_STAT: n.prdata = stat;
                REG_DATA: n.prdata = {24'h000000, q.rbyte};
                REG_SYN: n.prdata = LB.ecc_syn;
                default: n.pslverr = 1'b1;
            endcase
        end else if (q.pready) begin
            n.pready = 1'b0;
            n.pslverr = 1'b0;
            n.prdata = 32'h00000000;
            if (PWRITE && !q.pslverr && PADDR == REG_CTRL) begin
                n.ecc_sel = PWDATA[C_ECC];
                n.dma_en = PWDATA[C_DMA];
                n.id_chk = PWDATA[C_IDCHK];
                n.mode = sbecc_mode_e'(PWDATA[C_MODE +: 2]);
                n.page = PWDATA[C_PAGE +: 3];
                n.span = (PWDATA[C_SPAN +: 4] > SPAN_MAX) ? SPAN_MAX :
                    PWDATA[C_SPAN +: 4];
            end
            if (PWRITE && !q.pslverr && PADDR == REG_CMD) begin
                n.page_ld = PWDATA[K_PAGE];
                n.ram_acc = PWDATA[K_ACC];
                n.ram_wr = PWDATA[K_WR] & PWDATA[K_ACC];
                n.ad_o = PWDATA[K_BYTE +: 8];
                n.ad_oe = PWDATA[K_WR] & PWDATA[K_ACC];
                n.cmd = PWDATA[K_CMD];
                if (PWDATA[K_XFER]) begin
                    n.xfer = drive_ok;
                    n.abort = ~drive_ok;
                    if (drive_ok && q.mode == SBECC_RD) begin
                        n.match = (LB.ecc_syn == q.prev_syn) & LB.ecc_nz;
                        n.prev_syn = LB.ecc_syn;
                        if (!LB.ecc_nz || n.match) begin
                            n.retry = 4'h0;
                        end else if (q.retry < RETRY_MAX) begin
                            n.retry = q.retry + 4'h1;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            q <= '0;
            q.span <= SPAN_RST;
            q.mode <= SBECC_WR;
        end else if (CE) begin
            q <= n;
        end
    end

    assign PREADY = q.pready;
    assign PRDATA = q.prdata;
    assign PSLVERR = q.pslverr;
    assign LB.page_ld = q.page_ld;
    assign LB.page_sel = q.page;
    assign LB.ram_acc = q.ram_acc;
    assign LB.ram_wr = q.ram_wr;
    assign LB.xfer_start = q.xfer;
    assign LB.xfer_mode = q.mode;
    assign LB.ecc_sel = q.ecc_sel;
    assign LB.dma_en = q.dma_en;
    assign LB.id_chk = q.id_chk;
    assign LB.cmd_start = q.cmd;
    assign LB.ad_p_o = q.ad_o;
    assign LB.ad_p_oe = q.ad_oe;
endmodule

/* rtl/sbecc_dev.sv */
// logic array end: buffer address counter, overflow, ecc/crc, reset timing
// assumes the local bus comes from the processor end on the same clock;
// option, dma ack, command strobe and reset pins are asynchronous
//
// Summary of operation
// - option pins read high open, low jumpered
// - processor loads three page bits of counter
// - every buffer access steps the address counter
// - idle counter top bits address task file
// - counter carry raises the overflow address bit
// - overflow drops dma request, starts ecc field
// - command phase end raises address bit three
// - write appends four ecc bytes after data
// - zero bytes follow while ecc stays selected
// - read compares recorded ecc, then ignores writes
// - nonzero comparison raises the ecc nonzero flag
// - long modes pass four check bytes raw
// - id fields checked by crc, data by ecc
// - correction span programmable, five recommended, eleven max
// - warm reset min 15us, stretched 1.35ms
// - cold reset min 10ms, stretched 128ms
// - processor splits sectors, one host interrupt
// - processor aborts on unready, seek, fault
// - processor retries id ten revolutions twice
// - correction only on two matching syndromes
// - dma request drops on ack, returns after
// - six command bytes stored in page zero
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module sbecc_dev
    import sbecc_pkg::*;
#(
    parameter int WARM_LEN = WARM_PULSE_CYC,
    parameter int COLD_MIN = COLD_MIN_CYC,
    parameter int COLD_LEN = COLD_PULSE_CYC
)(
    // clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic CE,
    // board pins
    input wire logic [3:0] OPTION_IN,
    input wire logic HOST_DMA_ACK,
    input wire logic HOST_CMD_STB,
    input wire logic WARM_RST_N,
    input wire logic COLD_RST_N,
    // board outputs
    output logic HOST_DMA_REQUEST,
    output logic [3:0] OPTION_VAL,
    output logic RESET_WARM,
    output logic RESET_COLD,
    // local bus
    sbecc_if.dev LB
);
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [1:0] s3;
        logic [CNT_W-1:0] cnt;
        logic ovf;
        logic act;
        logic cmd_rdy;
        logic [2:0] cmd_n;
        sbecc_mode_e mode;
        sbecc_phase_e ph;
        logic [1:0] tail_n;
        logic [31:0] ecc;
        logic [31:0] tail;
        logic [31:0] syn;
        logic nz;
        logic [15:0] crc;
        logic drq;
        logic [1:0][RST_CW-1:0] hold;
        logic [1:0][RST_CW-1:0] pulse;
        logic [7:0] ad_o;
        logic ad_oe;
    } sbecc_dev_s;
    sbecc_dev_s q, n;

    function automatic logic [31:0] ecc_step(logic [31:0] r, logic [7:0] b);
        logic [31:0] v;
        v = r;
        for (int i = 7; i >= 0; i--) begin
            v = {v[30:0], 1'b0} ^ ((v[31] ^ b[i]) ? ECC_POLY : 32'h00000000);
        end
        return v;
    endfunction

    function automatic logic [15:0] crc_step(logic [15:0] r, logic [7:0] b);
        logic [15:0] v;
        v = r;
        for (int i = 7; i >= 0; i--) begin
            v = {v[14:0], 1'b0} ^ ((v[15] ^ b[i]) ? CRC_POLY : 16'h0000);
        end
        return v;
    endfunction

    logic dack, dack_fall, cmd_rise, acc, is_long, wr_acc, rd_acc;
    logic [CNT_W:0] inc;
    logic [1:0][RST_CW-1:0] min_c, len_c;
    logic [1:0] rst_in;

    always_comb begin
        n = q;
        n.s1 = {OPTION_IN, HOST_DMA_ACK, HOST_CMD_STB, WARM_RST_N, COLD_RST_N};
        n.s2 = q.s1;
        n.s3 = q.s2[3:2];
        dack = q.s2[3];
        dack_fall = ~q.s2[3] & q.s3[1];
        cmd_rise = q.s2[2] & ~q.s3[0];
        is_long = (q.mode == SBECC_WLONG) || (q.mode == SBECC_RLONG);
        acc = LB.ram_acc | (dack_fall & LB.dma_en) | cmd_rise;
        wr_acc = LB.ram_acc & LB.ram_wr;
        rd_acc = LB.ram_acc & ~LB.ram_wr;
        inc = {1'b0, q.cnt} + {{CNT_W{1'b0}}, 1'b1};
        if (acc) begin
            n.cnt = inc[CNT_W-1:0];
            if (inc[CNT_W]) begin
                n.ovf = 1'b1;
            end
        end
        if (cmd_rise) begin
            n.cmd_n = q.cmd_n + 3'h1;
            if (q.cmd_n == CMD_LAST) begin
                n.cmd_rdy = 1'b1;
            end
        end
        if (LB.cmd_start) begin
            n.cnt = '0;
            n.ovf = 1'b0;
            n.cmd_n = 3'h0;
            n.cmd_rdy = 1'b0;
        end
        if (LB.page_ld) begin
            n.cnt = {LB.page_sel, {PAGE_LSB{1'b0}}};
            n.ovf = 1'b0;
            n.cmd_rdy = 1'b0;
        end
        if (LB.id_chk && LB.ram_acc) begin
            n.crc = crc_step(q.crc, LB.ad);
        end
        case (q.ph)
            SBECC_DATA: begin
                if (q.act && LB.ram_acc && !LB.id_chk && !is_long) begin
                    n.ecc = ecc_step(q.ecc, LB.ad);
                end
                if (q.act && n.ovf) begin
                    n.ph = SBECC_TAIL;
                    n.tail_n = 2'h0;
                    n.tail = (q.mode == SBECC_WR) ? n.ecc : 32'h00000000;
                end
            end
            SBECC_TAIL: begin
                if (is_long && wr_acc) begin
                    n.tail = {q.tail[23:0], LB.ad};
                end else if (q.mode != SBECC_RD && rd_acc) begin
                    n.tail = {q.tail[23:0], 8'h00};
                    n.tail_n = q.tail_n + 2'h1;
                    if (q.mode == SBECC_WR && q.tail_n == TAIL_LAST) begin
                        n.ph = SBECC_DONE;
                    end
                end else if (q.mode == SBECC_RD && wr_acc) begin
                    n.tail = {q.tail[23:0], LB.ad};
                    n.tail_n = q.tail_n + 2'h1;
                    if (q.tail_n == TAIL_LAST) begin
                        n.syn = q.ecc ^ {q.tail[23:0], LB.ad};
                        n.nz = (q.ecc != {q.tail[23:0], LB.ad});
                        n.ph = SBECC_DONE;
                    end
                end
            end
            SBECC_DONE: n.ph = SBECC_DONE;
            default: n.ph = SBECC_DATA;
        endcase
        if (LB.xfer_start) begin
            n.mode = LB.xfer_mode;
            n.ph = SBECC_DATA;
            n.act = 1'b1;
            n.ovf = 1'b0;
            n.ecc = ECC_INIT;
            n.tail = 32'h00000000;
            n.tail_n = 2'h0;
            n.syn = 32'h00000000;
            n.nz = 1'b0;
            n.crc = CRC_INIT;
        end else if (q.act && q.ph == SBECC_DONE) begin
            n.act = 1'b0;
        end
        n.drq = LB.dma_en & n.act & ~n.ovf & ~dack & (n.ph == SBECC_DATA);
        n.ad_o = n.tail[31:24];
        n.ad_oe = LB.ecc_sel & (n.ph != SBECC_DATA) & (n.mode != SBECC_RD);
        min_c[0] = RST_CW'(WARM_MIN_CYC);
        len_c[0] = RST_CW'(WARM_LEN);
        min_c[1] = RST_CW'(COLD_MIN);
        len_c[1] = RST_CW'(COLD_LEN);
        rst_in[0] = ~q.s2[1];
        rst_in[1] = ~q.s2[0];
        for (int k = 0; k < 2; k++) begin
            if (q.pulse[k] != '0) begin
                n.pulse[k] = q.pulse[k] - RST_CW'(1);
            end
            if (!rst_in[k]) begin
                n.hold[k] = '0;
            end else if (q.hold[k] != min_c[k]) begin
                n.hold[k] = q.hold[k] + RST_CW'(1);
                if (q.hold[k] == min_c[k] - RST_CW'(1)) begin
                    n.pulse[k] = len_c[k];
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            q <= '0;
            q.s1 <= 8'hF3;
            q.s2 <= 8'hF3;
            q.s3 <= 2'h0;
            q.crc <= CRC_INIT;
            q.ph <= SBECC_DATA;
            q.mode <= SBECC_WR;
        end else if (CE) begin
            q <= n;
        end
    end

    assign HOST_DMA_REQUEST = q.drq;
    assign OPTION_VAL = q.s2[7:4];
    assign RESET_WARM = (q.pulse[0] != '0);
    assign RESET_COLD = (q.pulse[1] != '0);
    assign LB.ra = {q.ovf, q.cnt[9:4], q.cnt[3] | q.cmd_rdy, q.cnt[2:0]};
    assign LB.tf_addr = {q.ovf, q.cnt[9:8]};
    assign LB.tf_valid = ~q.act;
    assign LB.ecc_nz = q.nz;
    assign LB.ecc_syn = q.syn;
    assign LB.id_err = (q.crc != 16'h0000);
    assign LB.ram_we_ok = ~((q.mode == SBECC_RD) & (q.ph == SBECC_DONE));
    assign LB.opt = q.s2[7:4];
    assign LB.rst_warm = RESET_WARM;
    assign LB.rst_cold = RESET_COLD;
    assign LB.ad_d_o = q.ad_o;
    assign LB.ad_d_oe = q.ad_oe;
endmodule

/* tb/sbecc_monitor.sv */
// checker on the local bus joining the processor end and the logic array
// assumes one clock domain and the bench reset, active low
`timescale 1ns/1ns
module sbecc_monitor
    import sbecc_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // processor end
    input wire logic page_ld,
    input wire logic [2:0] page_sel,
    input wire logic ram_acc,
    input wire logic xfer_start,
    input sbecc_mode_e xfer_mode,
    input wire logic ecc_sel,
    input wire logic cmd_start,
    // logic array end
    input wire logic [10:0] ra,
    input wire logic [2:0] tf_addr,
    input wire logic tf_valid,
    input wire logic ecc_nz,
    input wire logic [31:0] ecc_syn,
    input wire logic ram_we_ok,
    input wire logic ad_d_oe
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    // ra[3] also carries command ready, so counter checks skip that bit, except the ra[9:0] trigger of chk_ovf_carry
    logic quiet;
    assign quiet = !page_ld && !cmd_start && !xfer_start;
    chk_page_load: assert property (
        page_ld && !ram_acc |=> !ra[10] && ra[9:4] == {$past(page_sel), 3'h0})
        else $error("page load left a wrong counter");
    chk_acc_step: assert property (
        ram_acc && quiet && !ra[10] |=> ra[2:0] == $past(ra[2:0]) + 3'h1)
        else $error("access did not step the counter");
    chk_ovf_carry: assert property (
        ram_acc && quiet && ra[9:0] == 10'h3FF |=> ra[10] && ra[2:0] == 3'h0)
        else $error("counter carry did not raise overflow");
    chk_tf_addr: assert property (
        tf_valid |-> tf_addr == ra[10:8])
        else $error("task file address differs from counter top");
    chk_tail_drive: assert property (
        $rose(ra[10]) && xfer_mode == SBECC_WR && ecc_sel |-> ##[0:1] ad_d_oe)
        else $error("check bytes not driven after data end");
    chk_nz_flag: assert property (
        !ram_we_ok && !$past(ram_we_ok) |-> ecc_nz == (ecc_syn != 32'h0))
        else $error("nonzero flag disagrees with result");
    chk_hold_result: assert property (
        !ram_we_ok && !xfer_start |=> $stable(ecc_syn) && $stable(ecc_nz))
        else $error("stored result changed before next transfer");
    chk_cmd_clear: assert property (
        cmd_start |=> ra[9:4] == 6'h0 && ra[2:0] == 3'h0)
        else $error("command phase did not start at page zero");
    cov_overflow: cover property ($rose(ra[10]));
    cov_nonzero: cover property ($rose(ecc_nz));
    cov_done: cover property ($fell(ram_we_ok));
endmodule

/* tb/sector_buffer_ecc_logic_test.sv */
// bench: apb traffic on the processor end, board pins on the logic array
// assumes shortened reset timing; buffer data are zeros, as no ram exists
`timescale 1ns/1ns
module sector_buffer_ecc_logic_test;
    import sbecc_pkg::*;
    localparam int WLEN = 50;
    localparam int CMIN = 20;
    localparam int CLEN = 60;
    `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
        num_errors++; $display("CHECK FAILED %0t got %0h exp %0h", \
        $time, a, b); end end
    logic CLK_SYS = 1'b0;
    logic RSTN = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [2:0] drv = 3'h3;
    logic [3:0] OPTION_IN = 4'hF;
    logic HOST_DMA_ACK = 1'b0;
    logic HOST_CMD_STB = 1'b0;
    logic WARM_RST_N = 1'b1;
    logic COLD_RST_N = 1'b1;
    logic PREADY, PSLVERR, HOST_DMA_REQUEST, RESET_WARM, RESET_COLD, er;
    logic [31:0] PRDATA, rd;
    logic [3:0] OPTION_VAL;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    sbecc_if sbecc_if_i ();
    sbecc_proc sbecc_proc_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(1'b1),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA),
        .PSLVERR(PSLVERR), .DRIVE_READY_IN(drv[0]),
        .SEEK_DONE_IN(drv[1]), .WRITE_FAULT_IN(drv[2]), .LB(sbecc_if_i));
    sbecc_dev #(.WARM_LEN(WLEN), .COLD_MIN(CMIN), .COLD_LEN(CLEN))
        sbecc_dev_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(1'b1),
        .OPTION_IN(OPTION_IN), .HOST_DMA_ACK(HOST_DMA_ACK),
        .HOST_CMD_STB(HOST_CMD_STB), .WARM_RST_N(WARM_RST_N),
        .COLD_RST_N(COLD_RST_N), .HOST_DMA_REQUEST(HOST_DMA_REQUEST),
        .OPTION_VAL(OPTION_VAL), .RESET_WARM(RESET_WARM),
        .RESET_COLD(RESET_COLD), .LB(sbecc_if_i));
    sbecc_monitor sbecc_monitor_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
        .page_ld(sbecc_if_i.page_ld), .page_sel(sbecc_if_i.page_sel),
        .ram_acc(sbecc_if_i.ram_acc), .xfer_start(sbecc_if_i.xfer_start),
        .xfer_mode(sbecc_if_i.xfer_mode), .ecc_sel(sbecc_if_i.ecc_sel),
        .cmd_start(sbecc_if_i.cmd_start), .ra(sbecc_if_i.ra),
        .tf_addr(sbecc_if_i.tf_addr), .tf_valid(sbecc_if_i.tf_valid),
        .ecc_nz(sbecc_if_i.ecc_nz), .ecc_syn(sbecc_if_i.ecc_syn),
        .ram_we_ok(sbecc_if_i.ram_we_ok), .ad_d_oe(sbecc_if_i.ad_d_oe));
    always #5 CLK_SYS = ~CLK_SYS;
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge CLK_SYS) begin
        cyc++;
        // whole run needs about six thousand cycles
        if (cyc == 40000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do @(posedge CLK_SYS); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic cmd(input int k);
        apb(1'b1, REG_CMD, 32'h1 << k);
    endtask
    task automatic acc(input int n, input logic w, input logic [7:0] b);
        repeat (n) apb(1'b1, REG_CMD, (32'(b) << K_BYTE) |
            (32'(w) << K_WR) | (32'h1 << K_ACC));
    endtask
    function automatic logic [31:0] ctl(input int m, input int p);
        return (32'h1 << C_ECC) | (32'h1 << C_DMA) | (32'(m) << C_MODE) |
            (32'(p) << C_PAGE) | (32'h5 << C_SPAN);
    endfunction
    task automatic t_basic();
        OPTION_IN <= 4'h6;
        apb(1'b0, REG_CTRL, 32'h0);
        `CHK(rd[C_SPAN+:4], SPAN_RST)
        apb(1'b1, REG_CTRL, 32'hF << C_SPAN);
        apb(1'b0, REG_CTRL, 32'h0);
        `CHK(rd[C_SPAN+:4], SPAN_MAX)
        apb(1'b0, REG_STAT, 32'h0);
        `CHK({rd[S_OPT+:4], OPTION_VAL}, 8'h66)
        apb(1'b0, 8'h14, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
    endtask
    task automatic t_abort();
        for (int i = 0; i < 3; i++) begin
            drv <= 3'h3 ^ (3'h1 << i);
            cmd(K_XFER);
            apb(1'b0, REG_STAT, 32'h0);
            `CHK(rd[S_ABORT], 1'b1)
        end
        drv <= 3'h3;
    endtask
    task automatic t_page();
        apb(1'b1, REG_CTRL, ctl(0, 3));
        cmd(K_PAGE);
        acc(5, 1'b0, 8'h00);
        apb(1'b0, REG_STAT, 32'h0);
        `CHK(rd[S_ADDR+:11], 11'h185)
        `CHK(rd[S_TF+:4], 4'h9)
    endtask
    task automatic t_cmd();
        apb(1'b1, REG_CTRL, ctl(0, 0));
        cmd(K_CMD);
        for (int i = 1; i <= 6; i++) begin
            HOST_CMD_STB <= 1'b1;
            repeat (4) @(posedge CLK_SYS);
            HOST_CMD_STB <= 1'b0;
            apb(1'b0, REG_STAT, 32'h0);
            `CHK(rd[S_CRDY], 1'(i == 6))
        end
        `CHK(rd[S_ADDR+:10], 10'h00E)
    endtask
    task automatic t_id();
        apb(1'b1, REG_CTRL, 32'h1 << C_IDCHK);
        cmd(K_XFER);
        acc(2, 1'b1, 8'hFF);
        apb(1'b0, REG_STAT, 32'h0);
        `CHK({rd[S_ABORT], rd[S_IDERR]}, 2'h0)
    endtask
    // a dma ack costs one access, so the count stays at one full page
    task automatic sector(input int m, input logic w);
        apb(1'b1, REG_CTRL, ctl(m, 7));
        cmd(K_XFER);
        cmd(K_PAGE);
        HOST_DMA_ACK <= 1'b1;
        repeat (5) @(posedge CLK_SYS);
        `CHK(HOST_DMA_REQUEST, 1'b0)
        HOST_DMA_ACK <= 1'b0;
        repeat (5) @(posedge CLK_SYS);
        `CHK(HOST_DMA_REQUEST, 1'b1)
        acc(127, w, 8'h00);
        apb(1'b0, REG_STAT, 32'h0);
        `CHK({rd[S_ADDR+10], HOST_DMA_REQUEST}, 2'h2)
    endtask
    task automatic tail(output logic [31:0] e);
        repeat (4) begin
            acc(1, 1'b0, 8'h00);
            apb(1'b0, REG_DATA, 32'h0);
            e = {e[23:0], rd[7:0]};
        end
    endtask
    task automatic t_ecc();
        logic [31:0] e, z, s;
        sector(SBECC_WR, 1'b0);
        tail(e);
        tail(z);
        `CHK(z, 32'h0)
        for (int k = 0; k < 2; k++) begin
            sector(SBECC_RD, 1'b1);
            for (int i = 3; i >= 0; i--)
                acc(1, 1'b1, e[8*i+:8] ^ 8'(k));
            apb(1'b0, REG_SYN, 32'h0);
            s = rd;
            acc(2, 1'b1, 8'hFF);
            apb(1'b0, REG_STAT, 32'h0);
            `CHK({rd[S_NZ], rd[S_WEOK]}, {1'(k), 1'b0})
            apb(1'b0, REG_SYN, 32'h0);
            `CHK({rd, s == 32'h0}, {s, 1'(k == 0)})
        end
    endtask
    task automatic t_long();
        logic [31:0] e;
        for (int m = 2; m < 4; m++) begin
            sector(m, 1'(m == 3));
            for (int i = 3; i >= 0; i--)
                acc(1, 1'b1, 8'h5A + 8'(i));
            tail(e);
            `CHK(e, 32'h5D5C5B5A)
            apb(1'b0, REG_STAT, 32'h0);
            `CHK(rd[S_NZ], 1'b0)
        end
    endtask
    task automatic rpulse(input logic c, input int len, input int x);
        int n;
        n = 0;
        if (c)
            COLD_RST_N <= 1'b0;
        else
            WARM_RST_N <= 1'b0;
        repeat (len) @(posedge CLK_SYS) n += c ? RESET_COLD : RESET_WARM;
        COLD_RST_N <= 1'b1;
        WARM_RST_N <= 1'b1;
        repeat (300) @(posedge CLK_SYS) n += c ? RESET_COLD : RESET_WARM;
        `CHK(n, x)
    endtask
    initial begin
        repeat (3) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        t_basic();
        t_abort();
        t_page();
        t_cmd();
        t_id();
        t_ecc();
        t_long();
        rpulse(1'b0, 100, 0);
        rpulse(1'b0, WARM_MIN_CYC + 100, WLEN);
        rpulse(1'b1, CMIN / 2, 0);
        rpulse(1'b1, CMIN + 10, CLEN);
        test_done();
    end
endmodule
